// File: core/hcce_defines.vh
// Purpose: constants of the channel command engine
// Assumes: 32-bit Avalon-MM word addressing by byte offset
// Notes: also holds the summary of the block's behaviour
// What this block does
// - Load spec registers, then write a command; engine copies them.
// - Every channel is off after reset.
// - No transmit data before transmit init loads the database.
// - Init fetches a descriptor; output waits for forward threshold.
// - A running channel short of data sends the idle code.
// - Transmit init completes after the first descriptor read.
// - No buffer space at init: failed vector, no list work.
// - Transmit off disables, tri-states slots, clears database.
// - Transmit off writes complete bit; host vector if flagged.
// - Transmit off completes when list work stops.
// - Abort/branch jumps to first pointer; abort if frame cut.
// - Abort vector only with buffered data.
// - Abort/branch completes after old list release.
// - Hold reset rereads; advances only if hold is zero.
// - Update replaces only the flag count; no vector.
// - Transmit idle sends the flag pattern; off channel only.
// - Debug shows the database; pointer shows next descriptor.
// - Receive init starts at first pointer; completes after copy.
// - Receive off stops input; abort vector if frame cut.
// - Receive off completes after the flush; clears database.
// - Receive abort/branch jumps; abort vector if frame in flight.
// - Receive hold reset rereads; resumes if hold is zero.
`ifndef HCCE_DEFINES_VH
`define HCCE_DEFINES_VH
`define HCCE_OFF_MODE 4'h0
`define HCCE_OFF_FTDP 4'h4
`define HCCE_OFF_FRDP 4'h8
`define HCCE_OFF_CMD 4'hC
`define HCCE_OFF_VEC 4'h0
`define HCCE_ADDR_W 5
`define HCCE_INTERFRAME_FLAG_COUNT_LSB 0
`define HCCE_PAT_LSB 8
`define HCCE_IDLE_LSB 16
`define HCCE_CPLEN_BIT 24
`define HCCE_CMD_TINIT 4'h1
`define HCCE_CMD_TOFF 4'h2
`define HCCE_CMD_TABR 4'h3
`define HCCE_CMD_THOLD 4'h4
`define HCCE_CMD_TIDLE 4'h5
`define HCCE_CMD_TDBG 4'h6
`define HCCE_CMD_TUPD 4'h7
`define HCCE_CMD_RINIT 4'h9
`define HCCE_CMD_ROFF 4'hA
`define HCCE_CMD_RABR 4'hB
`define HCCE_CMD_RHOLD 4'hC
`define HCCE_CMD_RDBG 4'hD
`define HCCE_DM_FETCH 2'h0
`define HCCE_DM_RELEASE 2'h1
`define HCCE_DM_FLUSH 2'h2
`define HCCE_DM_REREAD 2'h3
`define HCCE_SEL_DATA 2'h0
`define HCCE_SEL_IDLE 2'h1
`define HCCE_SEL_FLAG 2'h2
`define HCCE_TX_OFF 2'h0
`define HCCE_TX_RUN 2'h1
`define HCCE_TX_IDLE 2'h2
`define HCCE_TX_HOLD 2'h3
`define HCCE_V_TCPL 0
`define HCCE_V_TFAIL 1
`define HCCE_V_TABT 2
`define HCCE_V_THI 3
`define HCCE_V_RCPL 4
`define HCCE_V_RABT 5
`endif

// File: core/hcce_channel_command_engine.v
// Purpose: per-channel transmit/receive command interpreter
// Assumes: data management, buffer and slot logic share clk
// Notes: one command in flight; vectors are sticky, write one to clear
`timescale 1ns/10ps
`default_nettype none
`include "hcce_defines.vh"
module hcce_channel_command_engine #(
    parameter NCH = 4,
    parameter CW = 2
) (
    input wire clk,
    input wire reset,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg dm_req_q,
    output reg [1:0] dm_op_q,
    output reg [CW-1:0] dm_chan_q,
    output reg [31:0] dm_addr_q,
    output reg dm_cpl_wr_q,
    output reg dm_rx_dir_q,
    input wire dm_done,
    input wire dm_hold,
    input wire dm_thi,
    input wire [31:0] dm_next_ptr,
    input wire buf_space_ok,
    input wire tx_buf_nonempty,
    input wire tx_frame_incomplete,
    input wire rx_frame_active,
    output reg tx_abort_seq_q,
    output reg rx_discard_q,
    input wire [CW-1:0] slot_chan,
    input wire tx_fwd_reached,
    input wire tx_data_avail,
    output reg tx_slot_oe_q,
    output reg [1:0] tx_slot_sel_q,
    output reg [7:0] tx_slot_byte_q,
    output reg [7:0] tx_interframe_flag_count_q,
    output reg rx_slot_accept_q
);
    localparam S_IDLE = 7'b0000001;
    localparam S_TFETCH = 7'b0000010;
    localparam S_TOFF = 7'b0000100;
    localparam S_TABR = 7'b0001000;
    localparam S_HOLD = 7'b0010000;
    localparam S_ROFF = 7'b0100000;
    localparam S_RFETCH = 7'b1000000;

    // Spec registers and command channel
    reg [31:0] mode_q;
    reg [31:0] ftdp_q;
    reg [31:0] frdp_q;
    reg [CW-1:0] cmd_chan_q;
    reg [3:0] cmd_q;
    reg dbg_view_q;
    reg dbg_rx_q;
    reg [5:0] vec_q;
    reg [CW-1:0] vec_chan_q;
    reg [6:0] state_q;
    // Channel database
    reg [1:0] tx_st_q [0:NCH-1];
    reg rx_on_q [0:NCH-1];
    reg rx_hold_q [0:NCH-1];
    reg tx_started_q [0:NCH-1];
    reg [31:0] db_mode_q [0:NCH-1];
    reg [31:0] db_tptr_q [0:NCH-1];
    reg [31:0] db_rptr_q [0:NCH-1];
    integer i;

    wire acc = (avs_read | avs_write) & ~avs_waitrequest;
    wire is_vec = avs_address[4];
    wire [3:0] off = avs_address[3:0];
    wire wr_cmd = acc & avs_write & ~is_vec & (off == `HCCE_OFF_CMD);
    wire wr_spec = acc & avs_write & ~is_vec & (off != `HCCE_OFF_CMD);
    wire [3:0] new_cmd = avs_writedata[3:0];
    wire [CW-1:0] new_chan = avs_writedata[8+CW-1:8];
    wire busy = ~state_q[0];
    wire start = wr_cmd & ~busy;
    wire [1:0] cst = tx_st_q[new_chan];
    wire [1:0] sst = tx_st_q[slot_chan];
    reg [5:0] vset;
    reg [31:0] rd_d;

    // Event sets win over software clears
    always @*
    begin
        vset = 6'h0;
        if (state_q[1] && dm_done)
            vset[`HCCE_V_TCPL] = 1'b1;
        if (start && new_cmd == `HCCE_CMD_TINIT && cst == `HCCE_TX_OFF
            && !buf_space_ok)
            vset[`HCCE_V_TFAIL] = 1'b1;
        if ((state_q[2] || state_q[3]) && dm_done)
            vset[`HCCE_V_TCPL] = 1'b1;
        if (state_q[2] && dm_done && dm_thi)
            vset[`HCCE_V_THI] = 1'b1;
        if (start && new_cmd == `HCCE_CMD_TABR && cst == `HCCE_TX_RUN
            && tx_buf_nonempty)
            vset[`HCCE_V_TABT] = 1'b1;
        if ((state_q[5] || state_q[6]) && dm_done)
            vset[`HCCE_V_RCPL] = 1'b1;
        if (start && (new_cmd == `HCCE_CMD_ROFF || new_cmd == `HCCE_CMD_RABR)
            && rx_on_q[new_chan] && rx_frame_active)
            vset[`HCCE_V_RABT] = 1'b1;
    end

    // Debug view returns the database mode and the debugged direction's pointer instead of spec registers
    always @*
    begin
        rd_d = 32'h0;
        if (is_vec)
        begin
            if (off == `HCCE_OFF_VEC)
                rd_d = {{(16-CW){1'b0}}, vec_chan_q, 10'h0, vec_q};
        end
        else if (off == `HCCE_OFF_MODE)
            rd_d = dbg_view_q ? db_mode_q[cmd_chan_q] : mode_q;
        else if (off == `HCCE_OFF_FTDP)
            rd_d = (dbg_view_q && !dbg_rx_q) ? db_tptr_q[cmd_chan_q] : ftdp_q;
        else if (off == `HCCE_OFF_FRDP)
            rd_d = (dbg_view_q && dbg_rx_q) ? db_rptr_q[cmd_chan_q] : frdp_q;
        else
            rd_d = {{(23-CW){1'b0}}, cmd_chan_q, 4'h0, busy, cmd_q};
    end

    // Avalon slave: one wait cycle, action at the accepting edge
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            mode_q <= 32'h0;
            ftdp_q <= 32'h0;
            frdp_q <= 32'h0;
            vec_q <= 6'h0;
        end
        else
        begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if ((avs_read | avs_write) & avs_waitrequest)
                avs_readdata <= rd_d;
            if (wr_spec && off == `HCCE_OFF_MODE)
                mode_q <= avs_writedata;
            if (wr_spec && off == `HCCE_OFF_FTDP)
                ftdp_q <= avs_writedata;
            if (wr_spec && off == `HCCE_OFF_FRDP)
                frdp_q <= avs_writedata;
            if (acc && avs_write && is_vec && off == `HCCE_OFF_VEC)
                vec_q <= (vec_q & ~avs_writedata[5:0]) | vset;
            else
                vec_q <= vec_q | vset;
        end
    end

    // Command sequencer and channel database
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= S_IDLE;
            cmd_q <= 4'h0;
            cmd_chan_q <= {CW{1'b0}};
            dbg_view_q <= 1'b0;
            dbg_rx_q <= 1'b0;
            vec_chan_q <= {CW{1'b0}};
            dm_req_q <= 1'b0;
            dm_op_q <= `HCCE_DM_FETCH;
            dm_chan_q <= {CW{1'b0}};
            dm_addr_q <= 32'h0;
            dm_cpl_wr_q <= 1'b0;
            dm_rx_dir_q <= 1'b0;
            tx_abort_seq_q <= 1'b0;
            rx_discard_q <= 1'b0;
            for (i = 0; i < NCH; i = i + 1)
            begin
                tx_st_q[i] <= `HCCE_TX_OFF;
                rx_on_q[i] <= 1'b0;
                rx_hold_q[i] <= 1'b0;
                tx_started_q[i] <= 1'b0;
                db_mode_q[i] <= 32'h0;
                db_tptr_q[i] <= 32'h0;
                db_rptr_q[i] <= 32'h0;
            end
        end
        else
        begin
            tx_abort_seq_q <= 1'b0;
            rx_discard_q <= 1'b0;
            if (vset != 6'h0)
                vec_chan_q <= busy ? cmd_chan_q : new_chan;
            if (wr_spec)
                dbg_view_q <= 1'b0;
            if (tx_fwd_reached && sst == `HCCE_TX_RUN)
                tx_started_q[slot_chan] <= 1'b1;
            if (start)
            begin
                cmd_q <= new_cmd;
                cmd_chan_q <= new_chan;
                dm_chan_q <= new_chan;
                // Commands out of sequence are dropped without a vector
                case (new_cmd)
                    `HCCE_CMD_TINIT:
                        if (cst == `HCCE_TX_OFF && buf_space_ok)
                        begin
                            db_mode_q[new_chan] <= mode_q;
                            db_tptr_q[new_chan] <= ftdp_q;
                            tx_st_q[new_chan] <= `HCCE_TX_RUN;
                            tx_started_q[new_chan] <= 1'b0;
                            dm_req_q <= 1'b1;
                            dm_op_q <= `HCCE_DM_FETCH;
                            dm_rx_dir_q <= 1'b0;
                            dm_addr_q <= ftdp_q;
                            state_q <= S_TFETCH;
                        end
                    `HCCE_CMD_TOFF:
                        if (cst != `HCCE_TX_OFF)
                        begin
                            tx_st_q[new_chan] <= `HCCE_TX_OFF;
                            tx_started_q[new_chan] <= 1'b0;
                            dm_req_q <= 1'b1;
                            dm_op_q <= `HCCE_DM_RELEASE;
                            dm_rx_dir_q <= 1'b0;
                            dm_cpl_wr_q <=
                                db_mode_q[new_chan][`HCCE_CPLEN_BIT];
                            dm_addr_q <= db_tptr_q[new_chan];
                            state_q <= S_TOFF;
                        end
                    `HCCE_CMD_TABR:
                        if (cst == `HCCE_TX_RUN || cst == `HCCE_TX_HOLD)
                        begin
                            tx_abort_seq_q <= tx_buf_nonempty
                                & tx_frame_incomplete;
                            db_tptr_q[new_chan] <= ftdp_q;
                            tx_st_q[new_chan] <= `HCCE_TX_RUN;
                            dm_req_q <= 1'b1;
                            dm_op_q <= `HCCE_DM_RELEASE;
                            dm_rx_dir_q <= 1'b0;
                            dm_cpl_wr_q <= 1'b0;
                            dm_addr_q <= ftdp_q;
                            state_q <= S_TABR;
                        end
                    `HCCE_CMD_THOLD:
                        if (cst == `HCCE_TX_HOLD)
                        begin
                            dm_req_q <= 1'b1;
                            dm_op_q <= `HCCE_DM_REREAD;
                            dm_rx_dir_q <= 1'b0;
                            dm_addr_q <= db_tptr_q[new_chan];
                            state_q <= S_HOLD;
                        end
                    `HCCE_CMD_TIDLE:
                        if (cst == `HCCE_TX_OFF)
                        begin
                            db_mode_q[new_chan] <= mode_q;
                            tx_st_q[new_chan] <= `HCCE_TX_IDLE;
                        end
                    `HCCE_CMD_TUPD:
                        if (cst != `HCCE_TX_OFF)
                            db_mode_q[new_chan][`HCCE_INTERFRAME_FLAG_COUNT_LSB+7:
                                `HCCE_INTERFRAME_FLAG_COUNT_LSB] <= mode_q[
                                `HCCE_INTERFRAME_FLAG_COUNT_LSB+7:`HCCE_INTERFRAME_FLAG_COUNT_LSB];
                    `HCCE_CMD_TDBG, `HCCE_CMD_RDBG:
                    begin
                        dbg_view_q <= 1'b1;
                        dbg_rx_q <= new_cmd[3];
                    end
                    `HCCE_CMD_RINIT:
                        if (!rx_on_q[new_chan])
                        begin
                            db_rptr_q[new_chan] <= frdp_q;
                            rx_on_q[new_chan] <= 1'b1;
                            rx_hold_q[new_chan] <= 1'b0;
                            dm_req_q <= 1'b1;
                            dm_op_q <= `HCCE_DM_FETCH;
                            dm_rx_dir_q <= 1'b1;
                            dm_addr_q <= frdp_q;
                            state_q <= S_RFETCH;
                        end
                    `HCCE_CMD_ROFF:
                        if (rx_on_q[new_chan])
                        begin
                            rx_on_q[new_chan] <= 1'b0;
                            rx_discard_q <= rx_frame_active;
                            dm_req_q <= 1'b1;
                            dm_op_q <= `HCCE_DM_FLUSH;
                            dm_rx_dir_q <= 1'b1;
                            dm_addr_q <= db_rptr_q[new_chan];
                            state_q <= S_ROFF;
                        end
                    `HCCE_CMD_RABR:
                        if (rx_on_q[new_chan])
                        begin
                            rx_discard_q <= rx_frame_active;
                            db_rptr_q[new_chan] <= frdp_q;
                            rx_hold_q[new_chan] <= 1'b0;
                            dm_req_q <= 1'b1;
                            dm_op_q <= `HCCE_DM_FETCH;
                            dm_rx_dir_q <= 1'b1;
                            dm_addr_q <= frdp_q;
                            state_q <= S_RFETCH;
                        end
                    `HCCE_CMD_RHOLD:
                        if (rx_on_q[new_chan] && rx_hold_q[new_chan])
                        begin
                            dm_req_q <= 1'b1;
                            dm_op_q <= `HCCE_DM_REREAD;
                            dm_rx_dir_q <= 1'b1;
                            dm_addr_q <= db_rptr_q[new_chan];
                            state_q <= S_HOLD;
                        end
                    default:
                        cmd_q <= new_cmd;
                endcase
            end
            else if (dm_done && busy)
            begin
                dm_req_q <= 1'b0;
                dm_cpl_wr_q <= 1'b0;
                state_q <= S_IDLE;
                case (state_q)
                    S_TFETCH, S_TABR:
                    begin
                        db_tptr_q[cmd_chan_q] <= dm_next_ptr;
                        tx_st_q[cmd_chan_q] <= dm_hold ? `HCCE_TX_HOLD
                            : `HCCE_TX_RUN;
                    end
                    S_TOFF:
                    begin
                        db_mode_q[cmd_chan_q] <= 32'h0;
                        db_tptr_q[cmd_chan_q] <= 32'h0;
                    end
                    S_HOLD:
                        if (!dm_hold)
                        begin
                            if (dm_rx_dir_q)
                            begin
                                db_rptr_q[cmd_chan_q] <= dm_next_ptr;
                                rx_hold_q[cmd_chan_q] <= 1'b0;
                            end
                            else
                            begin
                                db_tptr_q[cmd_chan_q] <= dm_next_ptr;
                                tx_st_q[cmd_chan_q] <= `HCCE_TX_RUN;
                            end
                        end
                    S_ROFF:
                    begin
                        db_rptr_q[cmd_chan_q] <= 32'h0;
                        rx_hold_q[cmd_chan_q] <= 1'b0;
                    end
                    S_RFETCH:
                    begin
                        db_rptr_q[cmd_chan_q] <= dm_next_ptr;
                        rx_hold_q[cmd_chan_q] <= dm_hold;
                    end
                    default:
                        state_q <= S_IDLE;
                endcase
            end
        end
    end

    // Serial slot control for the channel owning the current slot
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tx_slot_oe_q <= 1'b0;
            tx_slot_sel_q <= `HCCE_SEL_IDLE;
            tx_slot_byte_q <= 8'h0;
            tx_interframe_flag_count_q <= 8'h0;
            rx_slot_accept_q <= 1'b0;
        end
        else
        begin
            tx_slot_oe_q <= (sst != `HCCE_TX_OFF);
            tx_interframe_flag_count_q <= db_mode_q[slot_chan][`HCCE_INTERFRAME_FLAG_COUNT_LSB+7:`HCCE_INTERFRAME_FLAG_COUNT_LSB];
            rx_slot_accept_q <= rx_on_q[slot_chan] & ~rx_hold_q[slot_chan];
            if (sst == `HCCE_TX_IDLE)
            begin
                tx_slot_sel_q <= `HCCE_SEL_FLAG;
                tx_slot_byte_q <=
                    db_mode_q[slot_chan][`HCCE_PAT_LSB+7:`HCCE_PAT_LSB];
            end
            else if (sst != `HCCE_TX_OFF && tx_started_q[slot_chan]
                && tx_data_avail)
            begin
                tx_slot_sel_q <= `HCCE_SEL_DATA;
                tx_slot_byte_q <= 8'h0;
            end
            else
            begin
                tx_slot_sel_q <= `HCCE_SEL_IDLE;
                tx_slot_byte_q <=
                    db_mode_q[slot_chan][`HCCE_IDLE_LSB+7:`HCCE_IDLE_LSB];
            end
        end
    end
endmodule // hcce_channel_command_engine
`default_nettype wire

// File: bench/hcce_dm_model.sv
// Purpose: data management partner of the engine
// Assumes: one request at a time
// Notes: answer fields are junk outside the done pulse
`timescale 1ns/10ps
`default_nettype none
module hcce_dm_model #(
    parameter logic [31:0] NEXT = 32'h0000_2000
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic dm_req_q,
    input wire logic [3:0] dly,
    input wire logic hold_v,
    input wire logic thi_v,
    output logic dm_done,
    output logic dm_hold,
    output logic dm_thi,
    output logic [31:0] dm_next_ptr
);
    logic [3:0] cnt_q;
    // Inverted outside the pulse so a late sample cannot pass
    assign dm_hold = dm_done ? hold_v : !hold_v;
    assign dm_thi = dm_done ? thi_v : !thi_v;
    assign dm_next_ptr = dm_done ? NEXT : ~NEXT;
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_q <= 4'h0;
            dm_done <= 1'b0;
        end
        else
        begin
            dm_done <= 1'b0;
            if (dm_req_q && !dm_done)
            begin
                if (cnt_q >= dly)
                begin
                    dm_done <= 1'b1;
                    cnt_q <= 4'h0;
                end
                else
                    cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule // hcce_dm_model
`default_nettype wire

// File: bench/hcce_engine_chk.sv
// Purpose: timing checks on the engine ports
// Assumes: single clock, reset active high
// Notes: bound to the engine below
`timescale 1ns/10ps
`default_nettype none
`include "hcce_defines.vh"
module hcce_engine_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic dm_req_q,
    input wire logic dm_done,
    input wire logic buf_space_ok,
    input wire logic tx_buf_nonempty,
    input wire logic tx_frame_incomplete,
    input wire logic rx_frame_active,
    input wire logic tx_abort_seq_q,
    input wire logic rx_discard_q,
    input wire logic tx_data_avail,
    input wire logic tx_slot_oe_q,
    input wire logic [1:0] tx_slot_sel_q
);
    wire cmd_w = avs_write && !avs_waitrequest && avs_address == 5'h0C;
    wire [3:0] cmd = avs_writedata[3:0];
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_wait_one;
        (avs_read || avs_write) && avs_waitrequest
            |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest not low one cycle");
    property p_dm_drop;
        dm_req_q && dm_done |=> !dm_req_q;
    endproperty
    a_dm_drop: assert property (p_dm_drop)
        else $error("request up after done");
    property p_fail_nodm;
        cmd_w && cmd == `HCCE_CMD_TINIT && !buf_space_ok && !dm_req_q
            |=> !dm_req_q [*2];
    endproperty
    a_fail_nodm: assert property (p_fail_nodm)
        else $error("fetch without buffer space");
    property p_nocpl;
        cmd_w && !dm_req_q && (cmd == `HCCE_CMD_TUPD ||
            cmd == `HCCE_CMD_TIDLE || cmd == `HCCE_CMD_TDBG ||
            cmd == `HCCE_CMD_RDBG) |=> !dm_req_q [*2];
    endproperty
    a_nocpl: assert property (p_nocpl)
        else $error("request after local command");
    property p_data_avail;
        tx_slot_oe_q && tx_slot_sel_q == `HCCE_SEL_DATA
            |-> $past(tx_data_avail);
    endproperty
    a_data_avail: assert property (p_data_avail)
        else $error("data slot without data");
    property p_rx_discard;
        rx_discard_q |-> $past(rx_frame_active) ##1 !rx_discard_q;
    endproperty
    a_rx_discard: assert property (p_rx_discard)
        else $error("bad discard pulse");
    property p_abort_seq;
        tx_abort_seq_q |-> $past(tx_buf_nonempty && tx_frame_incomplete);
    endproperty
    a_abort_seq: assert property (p_abort_seq)
        else $error("abort without cut frame");
    property p_dm_cause;
        $rose(dm_req_q) |-> $past(cmd_w) || $past(cmd_w, 2);
    endproperty
    a_dm_cause: assert property (p_dm_cause)
        else $error("request without command");
endmodule // hcce_engine_chk
bind hcce_channel_command_engine hcce_engine_chk i_chk (.*);
`default_nettype wire

// File: bench/tb.sv
// Purpose: self-checking bench of the command engine
// Assumes: partner model answers data management requests
// Notes: vectors are read and cleared after each command; the later idle, update and debug runs skip the compare
`timescale 1ns/10ps
`default_nettype none
`include "hcce_defines.vh"
module tb;
    logic clk, reset, avs_read, avs_write, avs_waitrequest, dm_done, dm_hold;
    logic dm_thi, dm_req_q, dm_cpl_wr_q, dm_rx_dir_q, buf_space_ok, hold_v;
    logic tx_buf_nonempty, tx_frame_incomplete, rx_frame_active, thi_v;
    logic tx_abort_seq_q, rx_discard_q, tx_fwd_reached, tx_data_avail;
    logic tx_slot_oe_q, rx_slot_accept_q, cplwr = 1'b0;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, dm_addr_q, dm_next_ptr, rd, vec;
    logic [1:0] dm_op_q, dm_chan_q, slot_chan, tx_slot_sel_q;
    logic [7:0] tx_slot_byte_q, tx_interframe_flag_count_q;
    logic [3:0] dly;
    int fail_count = 0, checks = 0, abort_n = 0, i;
    // Command code beside the vector bits it must leave
    logic [11:0] rows [12] = '{12'h101, 12'h700, 12'h600, 12'h400, 12'h301,
        12'h201, 12'h500, 12'h910, 12'hC00, 12'hB10, 12'hD00, 12'hA10};
    hcce_channel_command_engine i_hcce_channel_command_engine (.clk, .reset,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .dm_req_q, .dm_op_q, .dm_chan_q, .dm_addr_q,
        .dm_cpl_wr_q, .dm_rx_dir_q, .dm_done, .dm_hold, .dm_thi, .dm_next_ptr,
        .buf_space_ok, .tx_buf_nonempty, .tx_frame_incomplete,
        .rx_frame_active, .tx_abort_seq_q, .rx_discard_q, .slot_chan,
        .tx_fwd_reached, .tx_data_avail, .tx_slot_oe_q, .tx_slot_sel_q,
        .tx_slot_byte_q, .tx_interframe_flag_count_q, .rx_slot_accept_q);
    hcce_dm_model i_hcce_dm_model (.clk, .reset, .dm_req_q, .dly, .hold_v,
        .thi_v, .dm_done, .dm_hold, .dm_thi, .dm_next_ptr);
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (tx_abort_seq_q)
            abort_n <= abort_n + 1;
        if (dm_req_q && dm_op_q == `HCCE_DM_RELEASE)
            cplwr <= dm_cpl_wr_q;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest && n < 50);
        if (avs_waitrequest)
        begin
            fail_count++;
            close_out;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic run(input logic [3:0] c, input logic [1:0] ch);
        int n;
        bus(1'b1, 5'h0C, {22'h0, ch, 4'h0, c});
        n = 0;
        do
        begin
            bus(1'b0, 5'h0C, 32'h0);
            n++;
        end while (rd[4] !== 1'b0 && n < 100);
        if (rd[4] !== 1'b0)
        begin
            fail_count++;
            close_out;
        end
        bus(1'b0, 5'h10, 32'h0);
        vec = rd & 32'h0000_003F;
        bus(1'b1, 5'h10, 32'h0000_003F);
    endtask
    task automatic slot(input logic [1:0] ch);
        slot_chan <= ch;
        repeat (3) @(posedge clk);
    endtask
    initial
    begin
        {avs_read, avs_write, tx_buf_nonempty, tx_frame_incomplete} = 4'h0;
        {rx_frame_active, tx_fwd_reached, hold_v, thi_v} = 4'h0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        buf_space_ok = 1'b1;
        tx_data_avail = 1'b1;
        slot_chan = 2'h0;
        dly = 4'h0;
        reset = 1'b1;
        repeat (10) @(posedge clk);
        check(avs_waitrequest, 1'b1);
        check({dm_req_q, tx_slot_oe_q, tx_slot_sel_q}, 4'h1);
        reset <= 1'b0;
        bus(1'b0, 5'h14, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, 5'h00, 32'h01AA_7E03);
        bus(1'b1, 5'h04, 32'h0000_1000);
        bus(1'b1, 5'h08, 32'h0000_3000);
        for (i = 0; i < 12; i++)
        begin
            dly <= i[0] ? 4'h6 : 4'h0;
            run(rows[i][11:8], 2'h1);
            check(vec, rows[i][7:0]);
            $display("row %0d done", i);
        end
        slot(2'h1);
        check({tx_slot_oe_q, tx_slot_sel_q, tx_slot_byte_q}, 11'h67E);
        buf_space_ok <= 1'b0;
        run(`HCCE_CMD_TINIT, 2'h2);
        check(vec, 32'h02);
        buf_space_ok <= 1'b1;
        run(`HCCE_CMD_TINIT, 2'h2);
        check(vec, 32'h01);
        run(`HCCE_CMD_TINIT, 2'h2);
        check(vec, 32'h00);
        run(`HCCE_CMD_TIDLE, 2'h2);
        slot(2'h2);
        check({tx_slot_oe_q, tx_slot_sel_q, tx_slot_byte_q}, 11'h5AA);
        tx_fwd_reached <= 1'b1;
        slot(2'h2);
        check({tx_slot_oe_q, tx_slot_sel_q}, 3'h4);
        tx_data_avail <= 1'b0;
        slot(2'h3);
        check(tx_slot_oe_q, 1'b0);
        $display("init and slot test done");
        bus(1'b1, 5'h00, 32'h0155_7E09);
        run(`HCCE_CMD_TUPD, 2'h2);
        slot(2'h2);
        check({tx_interframe_flag_count_q, tx_slot_sel_q, tx_slot_byte_q}, 18'h025AA);
        run(`HCCE_CMD_TDBG, 2'h2);
        bus(1'b0, 5'h04, 32'h0);
        check(rd, 32'h0000_2000);
        bus(1'b1, 5'h04, 32'h0000_1000);
        {tx_buf_nonempty, tx_frame_incomplete} <= 2'h3;
        run(`HCCE_CMD_TABR, 2'h2);
        check({vec, abort_n}, {32'h05, 32'h1});
        {tx_buf_nonempty, tx_frame_incomplete, thi_v} <= 3'h1;
        run(`HCCE_CMD_TOFF, 2'h2);
        check({vec, cplwr}, 33'h13);
        slot(2'h2);
        check(tx_slot_oe_q, 1'b0);
        $display("abort and off test done");
        run(`HCCE_CMD_RINIT, 2'h2);
        slot(2'h2);
        check({vec, rx_slot_accept_q}, 33'h21);
        rx_frame_active <= 1'b1;
        run(`HCCE_CMD_RABR, 2'h2);
        check(vec, 32'h30);
        run(`HCCE_CMD_ROFF, 2'h2);
        slot(2'h2);
        check({vec, rx_slot_accept_q}, 33'h60);
        $display("receive test done");
        close_out;
    end
endmodule // tb
`default_nettype wire
